// ---- src/sbmd_dma_engine.sv ----
/*
  Bus-master DMA engine with 32/16 funnel, descriptor-list scatter-gather
  and a two-entry buffer toward the SCSI FIFO. Assumes a memory slave
  that answers each request with a one-cycle mem_ack, and synchronous
  register strobes on a byte-offset address.
// Summary of operation
// - funnel splits words to halves and back
// - start count holds 24 bits, top reserved
// - working counters readable, never writable
// - direction bit one means scsi to memory
// - completion enable raises irq on done/error
// - page enable raises irq per page
// - list enable selects 4k page scatter-gather
// - idle code stops engine, flags untouched
// - flush writes held bytes, sets flag
// - abort code stops engine, sets abort flag
// - start code begins transfer with settings
// - entry bits 31:12 are page frame
// - list start write copies into pointer
// - first fetch merges frame with start offset
// - page rollover fetches next entry
// - zero count stops address advance
*/
`timescale 1ns/10ps
`include "sbmd_cfg.svh"

module sbmd_buffer #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  assign in_ready = cnt_q != (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= bump(wp_q);
      end
      if (pop) begin
        rp_q <= bump(rp_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module sbmd_dma_engine #(
  parameter int CNT_W = `SBMD_CNT_W,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // memory master
  output sbmd_pkg::sbmd_mem_req_t mem_o,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  // toward scsi fifo
  output logic tx_valid,
  input wire logic tx_ready,
  output sbmd_pkg::sbmd_half_t tx_word,
  // from scsi fifo
  input wire logic rx_valid,
  output logic rx_ready,
  input wire sbmd_pkg::sbmd_half_t rx_word,
  // interrupts
  input wire logic scsi_irq,
  output logic irq
);
  sbmd_pkg::sbmd_state_t state_q;
  sbmd_pkg::sbmd_half_t tx_in;
  logic [7:0] cmd_q, flags_q, ev;
  logic [CNT_W-1:0] stc_q, cnt_q;
  logic [31:0] spa_q, wac_q, dla_q, ptr_q, word_q, rdata_q, nxt, rx_lanes;
  logic [29:0] waddr_q;
  logic [3:0] be_q, rx_be;
  logic [1:0] nb, code, lane;
  logic flushing_q, buf_ready, cmd_wr, dla_wr, ctl_cmd, rollover;
  logic start_cmd, idle_cmd, abort_cmd, flush_cmd, tx_push, rx_take, ack_ok;

  // bytes moved per half: one at an odd address or on the last byte
  function automatic logic [1:0] unit_bytes(input logic [CNT_W-1:0] c, input logic odd);
    unit_bytes = (c == CNT_W'(1) || odd) ? 2'h1 : 2'h2;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  // command decode
  assign code = reg_wdata[1:0];
  assign cmd_wr = reg_wr && hit(reg_addr, `SBMD_OFS_CMD);
  assign dla_wr = reg_wr && hit(reg_addr, `SBMD_OFS_DLA);
  assign start_cmd = cmd_wr && code == `SBMD_C_START && cmd_q[1:0] != `SBMD_C_START;
  assign idle_cmd = cmd_wr && code == `SBMD_C_IDLE;
  assign abort_cmd = cmd_wr && code == `SBMD_C_ABORT;
  assign flush_cmd = cmd_wr && code == `SBMD_C_FLUSH && cmd_q[`SBMD_DIR] && state_q == sbmd_pkg::ST_RX;
  assign ctl_cmd = start_cmd || idle_cmd || abort_cmd || flush_cmd;

  // funnel datapath
  assign nb = unit_bytes(cnt_q, wac_q[0]);
  assign nxt = wac_q + 32'(nb);
  assign rollover = nxt[`SBMD_PG_LO:0] == '0;
  assign lane = wac_q[1:0];
  assign tx_push = state_q == sbmd_pkg::ST_TX && buf_ready && !ctl_cmd;
  assign rx_take = state_q == sbmd_pkg::ST_RX && rx_valid && !ctl_cmd;
  assign rx_ready = state_q == sbmd_pkg::ST_RX && !ctl_cmd;
  assign ack_ok = mem_o.req && mem_ack && !mem_err && !ctl_cmd;

  always_comb begin
    tx_in.single = nb == 2'h1;
    tx_in.data = wac_q[1] ? word_q[31:16] : word_q[15:0];
    if (nb == 2'h1) begin
      tx_in.data = {8'h00, word_q[lane*8 +: 8]};
    end
  end

  always_comb begin
    logic [1:0] l;
    l = lane;
    rx_lanes = word_q;
    rx_be = be_q;
    for (int k = 0; k < 2; k++) begin
      if (2'(k) < nb) begin
        l = 2'(lane + 2'(k));
        rx_lanes[l*8 +: 8] = rx_word.data[k*8 +: 8];
        rx_be[l] = 1'b1;
      end
    end
  end

  sbmd_buffer #(
    .WIDTH($bits(sbmd_pkg::sbmd_half_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_push),
    .in_ready(buf_ready),
    .in_data(tx_in),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_word)
  );

  // memory request
  always_comb begin
    mem_o.req = state_q == sbmd_pkg::ST_RD || state_q == sbmd_pkg::ST_WR
      || state_q == sbmd_pkg::ST_DESC;
    mem_o.we = state_q == sbmd_pkg::ST_WR;
    mem_o.wdata = word_q;
    mem_o.be = mem_o.we ? be_q : 4'hf;
    mem_o.addr = {waddr_q, 2'h0};
    if (state_q == sbmd_pkg::ST_DESC) begin
      mem_o.addr = {ptr_q[31:2], 2'h0};
    end else if (state_q == sbmd_pkg::ST_RD) begin
      mem_o.addr = {wac_q[31:2], 2'h0};
    end
  end

  // programmed registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= `SBMD_RST8;
      stc_q <= '0;
      spa_q <= `SBMD_RST32;
      dla_q <= `SBMD_RST32;
    end else if (reg_wr) begin
      if (cmd_wr) begin
        cmd_q <= reg_wdata[7:0];
      end
      if (hit(reg_addr, `SBMD_OFS_STC)) begin
        stc_q <= reg_wdata[CNT_W-1:0];
      end
      if (hit(reg_addr, `SBMD_OFS_SPA)) begin
        spa_q <= reg_wdata;
      end
      if (dla_wr) begin
        dla_q <= reg_wdata;
      end
    end
  end

  // descriptor pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= `SBMD_RST32;
    end else if (dla_wr) begin
      ptr_q <= reg_wdata;
    end else if (state_q == sbmd_pkg::ST_DESC && ack_ok) begin
      ptr_q <= ptr_q + `SBMD_DESC_STEP;
    end
  end

  // transfer sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sbmd_pkg::ST_IDLE;
      cnt_q <= '0;
      wac_q <= `SBMD_RST32;
      word_q <= `SBMD_RST32;
      be_q <= '0;
      waddr_q <= '0;
      flushing_q <= 1'b0;
    end else if (idle_cmd || abort_cmd) begin
      state_q <= sbmd_pkg::ST_IDLE;
      flushing_q <= 1'b0;
    end else if (start_cmd) begin
      cnt_q <= stc_q;
      wac_q <= spa_q;
      be_q <= '0;
      flushing_q <= 1'b0;
      if (stc_q == '0) begin
        state_q <= sbmd_pkg::ST_HALT;
      end else if (reg_wdata[`SBMD_DLE]) begin
        state_q <= sbmd_pkg::ST_DESC;
      end else if (reg_wdata[`SBMD_DIR]) begin
        state_q <= sbmd_pkg::ST_RX;
      end else begin
        state_q <= sbmd_pkg::ST_RD;
      end
    end else if (flush_cmd) begin
      if (be_q != '0) begin
        state_q <= sbmd_pkg::ST_WR;
        flushing_q <= 1'b1;
      end else begin
        state_q <= sbmd_pkg::ST_HALT;
      end
    end else if (mem_o.req && mem_ack && mem_err) begin
      state_q <= sbmd_pkg::ST_HALT;
    end else begin
      case (state_q)
        sbmd_pkg::ST_DESC: begin
          if (mem_ack) begin
            wac_q[31:`SBMD_PG_HI] <= mem_rdata[31:`SBMD_PG_HI];
            state_q <= cmd_q[`SBMD_DIR] ? sbmd_pkg::ST_RX : sbmd_pkg::ST_RD;
          end
        end
        sbmd_pkg::ST_RD: begin
          if (mem_ack) begin
            word_q <= mem_rdata;
            state_q <= sbmd_pkg::ST_TX;
          end
        end
        sbmd_pkg::ST_TX: begin
          if (buf_ready) begin
            cnt_q <= cnt_q - CNT_W'(nb);
            wac_q <= nxt;
            if (cnt_q == CNT_W'(nb)) begin
              state_q <= sbmd_pkg::ST_HALT;
            end else if (rollover && cmd_q[`SBMD_DLE]) begin
              state_q <= sbmd_pkg::ST_DESC;
            end else if (nxt[1:0] == 2'h0) begin
              state_q <= sbmd_pkg::ST_RD;
            end
          end
        end
        sbmd_pkg::ST_RX: begin
          if (rx_valid) begin
            word_q <= rx_lanes;
            be_q <= rx_be;
            waddr_q <= wac_q[31:2];
            cnt_q <= cnt_q - CNT_W'(nb);
            wac_q <= nxt;
            if (cnt_q == CNT_W'(nb) || nxt[1:0] == 2'h0) begin
              state_q <= sbmd_pkg::ST_WR;
            end
          end
        end
        sbmd_pkg::ST_WR: begin
          if (mem_ack) begin
            be_q <= '0;
            if (flushing_q || cnt_q == '0) begin
              state_q <= sbmd_pkg::ST_HALT;
            end else if (wac_q[`SBMD_PG_LO:0] == '0 && cmd_q[`SBMD_DLE]) begin
              state_q <= sbmd_pkg::ST_DESC;
            end else begin
              state_q <= sbmd_pkg::ST_RX;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // status events
  always_comb begin
    ev = 8'h00;
    ev[`SBMD_F_DONE] = (start_cmd && stc_q == '0) || (tx_push && cnt_q == CNT_W'(nb))
      || (state_q == sbmd_pkg::ST_WR && ack_ok && !flushing_q && cnt_q == '0);
    ev[`SBMD_F_ERR] = mem_o.req && mem_ack && mem_err && !ctl_cmd;
    ev[`SBMD_F_ABORT] = abort_cmd;
    ev[`SBMD_F_FLUSHED] = (flush_cmd && be_q == '0)
      || (state_q == sbmd_pkg::ST_WR && ack_ok && flushing_q);
    ev[`SBMD_F_SCSI] = scsi_irq;
    ev[`SBMD_F_PAGE] = cmd_q[`SBMD_DLE] && (tx_push || rx_take)
      && rollover && cnt_q != CNT_W'(nb);
  end

  // flags clear on status read; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= `SBMD_RST8;
    end else if (reg_rd && hit(reg_addr, `SBMD_OFS_STAT)) begin
      flags_q <= ev;
    end else begin
      flags_q <= flags_q | ev;
    end
  end

  assign irq = (cmd_q[`SBMD_CIE] && (flags_q[`SBMD_F_DONE] || flags_q[`SBMD_F_ERR]))
    || (cmd_q[`SBMD_PIE] && flags_q[`SBMD_F_PAGE]);

  // register read; working counters have no write path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= `SBMD_RST32;
    end else if (reg_rd) begin
      case (reg_addr)
        `SBMD_OFS_CMD: rdata_q <= {24'h0, cmd_q};
        `SBMD_OFS_STC: rdata_q <= 32'(stc_q);
        `SBMD_OFS_SPA: rdata_q <= spa_q;
        `SBMD_OFS_WBC: rdata_q <= 32'(cnt_q);
        `SBMD_OFS_WAC: rdata_q <= wac_q;
        `SBMD_OFS_STAT: rdata_q <= {24'h0, flags_q & `SBMD_F_MASK};
        `SBMD_OFS_DLA: rdata_q <= dla_q;
        `SBMD_OFS_PTR: rdata_q <= ptr_q;
        default: rdata_q <= `SBMD_RST32;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  AST_STC_HI:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == `SBMD_OFS_STC |=> reg_rdata[31:24] == 8'h00)
      else $error("start count upper byte not zero");
  AST_WBC_RO:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == `SBMD_OFS_WBC && state_q == sbmd_pkg::ST_IDLE |=> $stable(cnt_q))
      else $error("byte counter changed by write");
  AST_START_DIR:
    assert property (@(posedge clk) disable iff (!rst_n)
      start_cmd && stc_q != '0 && !reg_wdata[`SBMD_DLE]
      |=> state_q == ($past(reg_wdata[`SBMD_DIR]) ? sbmd_pkg::ST_RX : sbmd_pkg::ST_RD))
      else $error("start took wrong direction");
  AST_IRQ_DONE:
    assert property (@(posedge clk) disable iff (!rst_n)
      ev[`SBMD_F_DONE] && cmd_q[`SBMD_CIE] && !cmd_wr |=> irq)
      else $error("done did not raise irq");
  AST_IRQ_PAGE:
    assert property (@(posedge clk) disable iff (!rst_n)
      ev[`SBMD_F_PAGE] && cmd_q[`SBMD_PIE] && !cmd_wr |=> irq)
      else $error("page end did not raise irq");
  AST_IDLE:
    assert property (@(posedge clk) disable iff (!rst_n)
      idle_cmd |=> state_q == sbmd_pkg::ST_IDLE)
      else $error("idle code did not stop engine");
  AST_FLUSH:
    assert property (@(posedge clk) disable iff (!rst_n)
      state_q == sbmd_pkg::ST_WR && flushing_q && ack_ok
      |=> flags_q[`SBMD_F_FLUSHED] && state_q == sbmd_pkg::ST_HALT)
      else $error("flush end not flagged");
  AST_ABORT:
    assert property (@(posedge clk) disable iff (!rst_n)
      abort_cmd |=> flags_q[`SBMD_F_ABORT] && state_q == sbmd_pkg::ST_IDLE)
      else $error("abort not flagged");
  AST_DLA_COPY:
    assert property (@(posedge clk) disable iff (!rst_n)
      dla_wr |=> ptr_q == $past(reg_wdata))
      else $error("pointer not copied");
  AST_PAGE_FRAME:
    assert property (@(posedge clk) disable iff (!rst_n)
      state_q == sbmd_pkg::ST_DESC && ack_ok && !dla_wr
      |=> wac_q[31:`SBMD_PG_HI] == $past(mem_rdata[31:`SBMD_PG_HI])
      && ptr_q == $past(ptr_q) + `SBMD_DESC_STEP)
      else $error("page frame not taken");
  AST_ZERO_HOLD:
    assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q == '0 && !start_cmd |=> $stable(wac_q))
      else $error("address moved at zero count");
endmodule

// ---- pkg/sbmd_cfg.svh ----
/*
  Register offsets, field positions, command codes and reset values
  of the DMA engine. Assumes byte offsets on an 8-bit register address.
*/
`ifndef SBMD_CFG_SVH
`define SBMD_CFG_SVH
`define SBMD_OFS_CMD 8'h40
`define SBMD_OFS_STC 8'h44
`define SBMD_OFS_SPA 8'h48
`define SBMD_OFS_WBC 8'h4c
`define SBMD_OFS_WAC 8'h50
`define SBMD_OFS_STAT 8'h54
`define SBMD_OFS_DLA 8'h58
`define SBMD_OFS_PTR 8'h5c
`define SBMD_DIR 7
`define SBMD_CIE 6
`define SBMD_PIE 5
`define SBMD_DLE 4
`define SBMD_C_IDLE 2'h0
`define SBMD_C_FLUSH 2'h1
`define SBMD_C_ABORT 2'h2
`define SBMD_C_START 2'h3
`define SBMD_F_DONE 0
`define SBMD_F_ERR 1
`define SBMD_F_ABORT 2
`define SBMD_F_FLUSHED 3
`define SBMD_F_SCSI 4
`define SBMD_F_PAGE 5
`define SBMD_F_MASK 8'h3f
`define SBMD_CNT_W 24
`define SBMD_PG_LO 11
`define SBMD_PG_HI 12
`define SBMD_DESC_STEP 32'h4
`define SBMD_RST8 8'h00
`define SBMD_RST32 32'h0
`endif

// ---- pkg/sbmd_pkg.sv ----
/*
  Types of the DMA engine: states, funnel half-word and memory request.
  Assumes the constants header for all numeric values.
*/
package sbmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DESC, ST_RD, ST_TX, ST_RX, ST_WR, ST_HALT
  } sbmd_state_t;
  typedef struct packed {
    logic [15:0] data;
    logic single;
  } sbmd_half_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } sbmd_mem_req_t;
endpackage

// ---- testbench/sbmd_far_model.sv ----
/*
  Far-side model: word memory behind the engine's master port and the
  scsi fifo end that sinks and sources half-words.
  Assumes one clock; the bench loads memory and rx halves directly.
*/
`timescale 1ns/10ps

module sbmd_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // memory slave
  input wire sbmd_pkg::sbmd_mem_req_t mem_o,
  output logic mem_ack,
  output logic mem_err,
  output logic [31:0] mem_rdata,
  // scsi fifo end
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_valid,
  input wire logic rx_ready,
  output sbmd_pkg::sbmd_half_t rx_word,
  // behaviour controls
  input wire logic slow,
  input wire logic stall,
  input wire logic [31:0] err_addr
);
  logic [31:0] mem [logic [31:0]];
  logic [15:0] rx_q [$];
  logic [15:0] rx_last;
  int wait_n;
  logic took;

  initial begin
    mem_ack = 1'b0;
    mem_err = 1'b0;
    mem_rdata = 32'h0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_word = '0;
    wait_n = 0;
  end

  always @(posedge clk) begin
    took = mem_ack;
    if (mem_ack && mem_o.we) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_o.be[b]) begin
          mem[mem_o.addr][8*b +: 8] = mem_o.wdata[8*b +: 8];
        end
      end
    end
    if (rx_valid && rx_ready) begin
      rx_last = rx_q.pop_front();
    end
    #1;
    // released read data never keeps its last value
    mem_ack = 1'b0;
    mem_err = 1'b0;
    mem_rdata = ~mem_rdata;
    if (!rst_n || !mem_o.req || took) begin
      wait_n = slow ? 3 : 0;
    end else if (wait_n > 0) begin
      wait_n--;
    end else begin
      mem_ack = 1'b1;
      mem_err = (mem_o.addr == err_addr);
      mem_rdata = mem.exists(mem_o.addr) ? mem[mem_o.addr] : ~mem_o.addr;
    end
    tx_ready = !stall && (!slow || !tx_ready);
    rx_valid = rst_n && (rx_q.size() != 0);
    rx_word.data = rx_valid ? rx_q[0] : ~rx_word.data;
    rx_word.single = 1'b0;
  end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench of the dma engine: register port tasks, far-side
  model, queued expectations for reads and tx halves.
  Assumes the design's package and constants header.
*/
`timescale 1ns/10ps
`include "sbmd_cfg.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst_n, reg_wr, reg_rd, scsi_irq, irq, slow, stall, chk_tx;
  logic rd_pend = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, err_addr, w;
  logic mem_ack, mem_err, tx_valid, tx_ready, rx_valid, rx_ready;
  sbmd_pkg::sbmd_mem_req_t mem_o;
  sbmd_pkg::sbmd_half_t tx_word, rx_word;
  logic [31:0] exp_rd [$];
  logic [31:0] exp_tx [$];
  logic [15:0] h [4];
  logic [31:0] lfsr = 32'hef21;
  int n_errors = 0;
  int checks = 0;

  always #5 clk = ~clk;

  sbmd_dma_engine #(.CNT_W(24), .BUF_DEPTH(2)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_o(mem_o), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
    .scsi_irq(scsi_irq), .irq(irq));

  sbmd_far_model far (
    .clk(clk), .rst_n(rst_n), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_word(rx_word), .slow(slow), .stall(stall), .err_addr(err_addr));

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction

  task automatic complete_run();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask

  // memory words plus the two halves each must yield, low half first
  task automatic load(input logic [31:0] a, input int nw);
    for (int i = 0; i < nw; i++) begin
      w = next_rand();
      far.mem[a + 4*i] = w;
      exp_tx.push_back({15'h0, w[15:0], 1'b0});
      exp_tx.push_back({15'h0, w[31:16], 1'b0});
    end
  endtask

  task automatic gen_rx(input int n);
    for (int i = 0; i < n; i++) begin
      w = next_rand();
      h[i] = w[15:0];
      far.rx_q.push_back(h[i]);
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    check({31'h0, irq}, 32'h1);
  endtask

  task automatic wait_tx();
    int n;
    n = 0;
    while (exp_tx.size() != 0 && n < 600) begin
      cyc(1);
      n++;
    end
    check(exp_tx.size(), 32'h0);
    cyc(4);
  endtask

  // read data one cycle after the strobe; tx halves in order
  always @(posedge clk) begin
    if (rd_pend) begin
      check(reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    end
    rd_pend <= reg_rd;
    if (tx_valid === 1'b1 && tx_ready && chk_tx) begin
      check({15'h0, tx_word}, exp_tx.size() ? exp_tx.pop_front() : 32'hx);
    end
  end

  initial begin
    #300000;
    n_errors++;
    complete_run();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, scsi_irq, slow, stall} = 6'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    err_addr = 32'hffff_fffc;
    chk_tx = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cyc(1);
    for (int a = 8'h40; a <= 8'h60; a += 4) begin
      rd(8'(a), 32'h0);
    end
    wr(`SBMD_OFS_STC, 32'hffff_ffff);
    rd(`SBMD_OFS_STC, 32'h00ff_ffff);
    wr(`SBMD_OFS_CMD, 32'h0000_00f0);
    rd(`SBMD_OFS_CMD, 32'h0000_00f0);
    wr(`SBMD_OFS_CMD, 32'h0);
    wr(`SBMD_OFS_WBC, 32'h1234_5678);
    wr(`SBMD_OFS_WAC, 32'h1234_5678);
    wr(`SBMD_OFS_PTR, 32'h1234_5678);
    rd(`SBMD_OFS_WBC, 32'h0);
    rd(`SBMD_OFS_WAC, 32'h0);
    wr(`SBMD_OFS_DLA, 32'h2000);
    rd(`SBMD_OFS_PTR, 32'h2000);
    scsi_irq = 1'b1;
    cyc(1);
    scsi_irq = 1'b0;
    rd(`SBMD_OFS_STAT, 32'h10);
    rd(`SBMD_OFS_STAT, 32'h0);
    // memory to scsi with the receiver stalled first
    load(32'h100, 2);
    wr(`SBMD_OFS_SPA, 32'h100);
    wr(`SBMD_OFS_STC, 32'h8);
    stall = 1'b1;
    wr(`SBMD_OFS_CMD, 32'h43);
    cyc(20);
    check({31'h0, tx_valid}, 32'h1);
    stall = 1'b0;
    wait_irq();
    wait_tx();
    rd(`SBMD_OFS_WBC, 32'h0);
    rd(`SBMD_OFS_STAT, 32'h1);
    wr(`SBMD_OFS_CMD, 32'h0);
    // descriptor list across a page boundary, slow far side
    far.mem[32'h2000] = 32'h0000_5abc;
    far.mem[32'h2004] = 32'h0000_7fff;
    load(32'h5ff8, 2);
    load(32'h7000, 2);
    wr(`SBMD_OFS_DLA, 32'h2000);
    wr(`SBMD_OFS_SPA, 32'h0ff8);
    wr(`SBMD_OFS_STC, 32'h10);
    slow = 1'b1;
    wr(`SBMD_OFS_CMD, 32'h33);
    wait_tx();
    check({31'h0, irq}, 32'h1);
    rd(`SBMD_OFS_PTR, 32'h2008);
    rd(`SBMD_OFS_STAT, 32'h21);
    check({31'h0, irq}, 32'h0);
    wr(`SBMD_OFS_CMD, 32'h0);
    slow = 1'b0;
    // scsi to memory
    gen_rx(4);
    wr(`SBMD_OFS_SPA, 32'h300);
    wr(`SBMD_OFS_STC, 32'h8);
    wr(`SBMD_OFS_CMD, 32'hc3);
    wait_irq();
    check(far.mem[32'h300], {h[1], h[0]});
    check(far.mem[32'h304], {h[3], h[2]});
    rd(`SBMD_OFS_STAT, 32'h1);
    wr(`SBMD_OFS_CMD, 32'h0);
    // bus error on the second word
    load(32'h500, 1);
    err_addr = 32'h504;
    wr(`SBMD_OFS_SPA, 32'h500);
    wr(`SBMD_OFS_STC, 32'h8);
    wr(`SBMD_OFS_CMD, 32'h43);
    wait_irq();
    wait_tx();
    rd(`SBMD_OFS_STAT, 32'h2);
    wr(`SBMD_OFS_CMD, 32'h0);
    err_addr = 32'hffff_fffc;
    // odd start address gives a single byte first
    w = next_rand();
    far.mem[32'h800] = w;
    exp_tx.push_back({15'h0, 8'h00, w[15:8], 1'b1});
    exp_tx.push_back({15'h0, w[31:16], 1'b0});
    wr(`SBMD_OFS_SPA, 32'h801);
    wr(`SBMD_OFS_STC, 32'h3);
    wr(`SBMD_OFS_CMD, 32'h43);
    wait_tx();
    rd(`SBMD_OFS_STAT, 32'h1);
    wr(`SBMD_OFS_CMD, 32'h0);
    // flush of a partial gather
    gen_rx(3);
    wr(`SBMD_OFS_SPA, 32'h400);
    wr(`SBMD_OFS_STC, 32'h10);
    wr(`SBMD_OFS_CMD, 32'h83);
    cyc(40);
    wr(`SBMD_OFS_CMD, 32'h81);
    cyc(40);
    rd(`SBMD_OFS_STAT, 32'h8);
    check(far.mem[32'h400], {h[1], h[0]});
    check({16'h0, far.mem[32'h404][15:0]}, {16'h0, h[2]});
    wr(`SBMD_OFS_CMD, 32'h0);
    // idle and abort in mid transfer
    chk_tx = 1'b0;
    slow = 1'b1;
    wr(`SBMD_OFS_SPA, 32'h600);
    wr(`SBMD_OFS_STC, 32'h40);
    wr(`SBMD_OFS_CMD, 32'h3);
    scsi_irq = 1'b1;
    cyc(12);
    scsi_irq = 1'b0;
    wr(`SBMD_OFS_CMD, 32'h0);
    cyc(30);
    rd(`SBMD_OFS_STAT, 32'h10);
    wr(`SBMD_OFS_CMD, 32'h3);
    cyc(12);
    wr(`SBMD_OFS_CMD, 32'h2);
    cyc(30);
    rd(`SBMD_OFS_STAT, 32'h4);
    cyc(4);
    complete_run();
  end
endmodule
